// ---- rtl/mdu_pkg.sv ----
// Constants and types of the multiply / divide unit
// Assumes a single 40 MHz clock and a plain register port
// Behaviour
// - Unsigned 16x16 multiply, 32/16 and 16/16 divide
// - Start only on register 5 ending order
// - Gaps between operand writes are harmless
// - Order 0,1,2,3,4,5 selects long divide
// - Order 0,1,4,5 selects short divide
// - Order 0,4,1,5 selects multiply
// - Long 17, short 9, multiply 11 cycles
// - Long divide: quotient 0-3, remainder 4-5
// - Short divide: quotient 0-1, remainder 4-5
// - Product low byte first in 0-3
// - Gaps between result reads are harmless
package mdu_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int        MDU_AW            = 4;
	localparam logic [3:0] MDU_ADDR_BYTE0   = 4'h0;
	localparam logic [3:0] MDU_ADDR_BYTE5   = 4'h5;
	localparam logic [3:0] MDU_ADDR_STATUS  = 4'h6;
	localparam logic [3:0] MDU_ADDR_IRQ_ST  = 4'h7;
	localparam logic [3:0] MDU_ADDR_IRQ_MSK = 4'h8;
	localparam int        MDU_SEQ_ERR_BIT   = 7;
	localparam int        MDU_OVF_BIT       = 6;
	localparam int        MDU_IRQ_DONE_BIT  = 0;
	localparam int        MDU_IRQ_ERR_BIT   = 1;
	localparam logic [7:0] MDU_STATUS_RST   = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int         MDU_CLK_MHZ     = 40;
	localparam logic [4:0] MDU_CYC_LONG    = 5'h11;
	localparam logic [4:0] MDU_CYC_SHORT   = 5'h09;
	localparam logic [4:0] MDU_CYC_MUL     = 5'h0B;
	localparam logic [15:0] MDU_PROD_LIMIT = 16'hFFFF;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		MDU_SQ_IDLE = 4'b0000,
		MDU_SQ_W0   = 4'b0001,
		MDU_SQ_W01  = 4'b0010,
		MDU_SQ_W012 = 4'b0011,
		MDU_SQ_W0123 = 4'b0100,
		MDU_SQ_W01234 = 4'b0101,
		MDU_SQ_W014 = 4'b0110,
		MDU_SQ_W04  = 4'b0111,
		MDU_SQ_W041 = 4'b1000
	} mdu_seq_e;

	typedef enum logic [1:0] {
		MDU_OP_LDIV = 2'b00,
		MDU_OP_SDIV = 2'b01,
		MDU_OP_MUL  = 2'b10
	} mdu_op_e;

endpackage

// ---- rtl/mdu_unit.sv ----
// Multiply / divide unit with sequence-selected operation
// Assumes the register master obeys the one-cycle strobe protocol
`timescale 1ns/1ps
module mdu_unit (
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire logic [mdu_pkg::MDU_AW-1:0] addr,
	input  wire logic [7:0]                wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output logic      [7:0]                rdata,
	output logic                           busy,
	output logic                           irq
);
	import mdu_pkg::*;

	// ****************************************
	// State
	// ****************************************
	logic [7:0]  data_r [0:5];
	mdu_seq_e    seq_r;
	mdu_seq_e    seq_nxt;
	mdu_op_e     op_r;
	logic [4:0]  cnt_r;
	logic        seq_err_r;
	logic        ovf_r;
	logic [1:0]  irq_st_r;
	logic [1:0]  irq_msk_r;
	logic        start;
	logic        done;
	logic        bad_order;
	logic        data_acc;
	logic [31:0] res_lo;
	logic [15:0] res_hi;
	logic        res_ovf;

	assign data_acc = (wr || rd) && (addr <= MDU_ADDR_BYTE5);

	// ****************************************
	// Write order tracking
	// ****************************************
	always_comb begin
		seq_nxt   = seq_r;
		start     = 1'b0;
		bad_order = 1'b0;
		if (wr && !busy && addr <= MDU_ADDR_BYTE5) begin
			unique case (seq_r)
				MDU_SQ_W0:     seq_nxt = (addr == 4'h1) ? MDU_SQ_W01 : (addr == 4'h4) ? MDU_SQ_W04 : MDU_SQ_IDLE;
				MDU_SQ_W01:    seq_nxt = (addr == 4'h2) ? MDU_SQ_W012 : (addr == 4'h4) ? MDU_SQ_W014 : MDU_SQ_IDLE;
				MDU_SQ_W012:   seq_nxt = (addr == 4'h3) ? MDU_SQ_W0123 : MDU_SQ_IDLE;
				MDU_SQ_W0123:  seq_nxt = (addr == 4'h4) ? MDU_SQ_W01234 : MDU_SQ_IDLE;
				MDU_SQ_W04:    seq_nxt = (addr == 4'h1) ? MDU_SQ_W041 : MDU_SQ_IDLE;
				MDU_SQ_W01234, MDU_SQ_W014, MDU_SQ_W041: begin
					seq_nxt = MDU_SQ_IDLE;
					start   = (addr == MDU_ADDR_BYTE5);
				end
				default:       seq_nxt = MDU_SQ_IDLE;
			endcase
			if (addr == MDU_ADDR_BYTE0)
				seq_nxt = MDU_SQ_W0;
			bad_order = !start && (seq_nxt == MDU_SQ_IDLE);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			seq_r <= MDU_SQ_IDLE;
		else
			seq_r <= seq_nxt;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			op_r <= MDU_OP_LDIV;
		else if (start) begin
			unique case (seq_r)
				MDU_SQ_W01234: op_r <= MDU_OP_LDIV;
				MDU_SQ_W014:   op_r <= MDU_OP_SDIV;
				default:       op_r <= MDU_OP_MUL;
			endcase
		end
	end

	// ****************************************
	// Calculation timer
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cnt_r <= 5'h00;
		else if (start) begin
			unique case (seq_r)
				MDU_SQ_W01234: cnt_r <= MDU_CYC_LONG - 5'h01;
				MDU_SQ_W014:   cnt_r <= MDU_CYC_SHORT - 5'h01;
				default:       cnt_r <= MDU_CYC_MUL - 5'h01;
			endcase
		end else if (cnt_r != 5'h00)
			cnt_r <= cnt_r - 5'h01;
	end

	assign busy = (cnt_r != 5'h00);
	assign done = (cnt_r == 5'h01);

	// ****************************************
	// Arithmetic
	// ****************************************
	always_comb begin
		logic [31:0] dvd;
		logic [15:0] dvs;
		logic [31:0] prod;
		dvd     = {data_r[3], data_r[2], data_r[1], data_r[0]};
		dvs     = {data_r[5], data_r[4]};
		prod    = {data_r[1], data_r[0]} * {data_r[5], data_r[4]};
		res_lo  = 32'h0000_0000;
		res_hi  = 16'h0000;
		res_ovf = 1'b0;
		unique case (op_r)
			MDU_OP_MUL: begin
				res_lo  = prod;
				res_hi  = dvs;
				res_ovf = prod > {16'h0000, MDU_PROD_LIMIT};
			end
			MDU_OP_SDIV: begin
				if (dvs == 16'h0000)
					res_ovf = 1'b1;
				else begin
					res_lo = {data_r[3], data_r[2], dvd[15:0] / dvs};
					res_hi = dvd[15:0] % dvs;
				end
			end
			default: begin
				if (dvs == 16'h0000)
					res_ovf = 1'b1;
				else begin
					res_lo = dvd / {16'h0000, dvs};
					res_hi = 16'((dvd % {16'h0000, dvs}));
				end
			end
		endcase
	end

	// ****************************************
	// Data registers
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 6; i++)
				data_r[i] <= 8'h00;
		end else if (done) begin
			data_r[0] <= res_lo[7:0];
			data_r[1] <= res_lo[15:8];
			data_r[2] <= res_lo[23:16];
			data_r[3] <= res_lo[31:24];
			data_r[4] <= res_hi[7:0];
			data_r[5] <= res_hi[15:8];
		end else if (wr && !busy && addr <= MDU_ADDR_BYTE5)
			data_r[addr[2:0]] <= wdata;
	end

	// ****************************************
	// Status
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			seq_err_r <= 1'b0;
		else if (bad_order || (data_acc && busy))
			seq_err_r <= 1'b1;
		else if (rd && addr == MDU_ADDR_STATUS)
			seq_err_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ovf_r <= 1'b0;
		else if (done)
			ovf_r <= res_ovf;
	end

	// ****************************************
	// Interrupts
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			irq_st_r <= 2'b00;
		else begin
			irq_st_r[MDU_IRQ_DONE_BIT] <= done || (irq_st_r[MDU_IRQ_DONE_BIT]
				&& !(wr && addr == MDU_ADDR_IRQ_ST && wdata[MDU_IRQ_DONE_BIT]));
			irq_st_r[MDU_IRQ_ERR_BIT] <= bad_order || (data_acc && busy) || (irq_st_r[MDU_IRQ_ERR_BIT]
				&& !(wr && addr == MDU_ADDR_IRQ_ST && wdata[MDU_IRQ_ERR_BIT]));
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			irq_msk_r <= 2'b00;
		else if (wr && addr == MDU_ADDR_IRQ_MSK)
			irq_msk_r <= wdata[1:0];
	end

	assign irq = |(irq_st_r & irq_msk_r);

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rdata <= 8'h00;
		else if (rd) begin
			if (addr <= MDU_ADDR_BYTE5)
				rdata <= busy ? 8'h00 : data_r[addr[2:0]];
			else if (addr == MDU_ADDR_STATUS)
				rdata <= {seq_err_r, ovf_r, 6'h00};
			else if (addr == MDU_ADDR_IRQ_ST)
				rdata <= {6'h00, irq_st_r};
			else if (addr == MDU_ADDR_IRQ_MSK)
				rdata <= {6'h00, irq_msk_r};
			else
				rdata <= 8'h00;
		end else
			rdata <= 8'h00;
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_long_order;
		wr && addr == 4'h4 && seq_r == MDU_SQ_W0123 && !busy;
	endsequence

	sequence s_short_order;
		wr && addr == 4'h4 && seq_r == MDU_SQ_W01 && !busy;
	endsequence

	sequence s_mul_order;
		wr && addr == 4'h1 && seq_r == MDU_SQ_W04 && !busy;
	endsequence

	sequence s_zero_write;
		wr && addr == MDU_ADDR_BYTE0 && !busy;
	endsequence

	sequence s_calc_quiet;
		busy && !done;
	endsequence

	sequence s_busy_read;
		rd && addr <= MDU_ADDR_BYTE5 && busy;
	endsequence

	sequence s_status_read;
		rd && addr == MDU_ADDR_STATUS;
	endsequence

	sequence s_mul_done;
		done && op_r == MDU_OP_MUL;
	endsequence

	sequence s_sdiv_done;
		done && op_r == MDU_OP_SDIV && (data_r[4] != 8'h00 || data_r[5] != 8'h00);
	endsequence

	sequence s_ldiv_done;
		done && op_r == MDU_OP_LDIV && (data_r[4] != 8'h00 || data_r[5] != 8'h00);
	endsequence

	a_long_start: assert property (@(posedge clk) disable iff (!reset_n)
		(wr && addr == MDU_ADDR_BYTE5 && seq_r == MDU_SQ_W01234 && !busy) |=> busy [*8] ##8 done ##1 !busy)
		else $error("long divide timing wrong");
	a_short_time: assert property (@(posedge clk) disable iff (!reset_n)
		(start && seq_r == MDU_SQ_W014) |=> ##7 done ##1 !busy)
		else $error("short divide timing wrong");
	a_mul_time: assert property (@(posedge clk) disable iff (!reset_n)
		(start && seq_r == MDU_SQ_W041) |=> ##9 done ##1 !busy)
		else $error("multiply timing wrong");
	a_start_only5: assert property (@(posedge clk) disable iff (!reset_n)
		start |-> (wr && addr == MDU_ADDR_BYTE5))
		else $error("start without register 5 write");
	a_long_track: assert property (@(posedge clk) disable iff (!reset_n)
		s_long_order |=> seq_r == MDU_SQ_W01234)
		else $error("long order not tracked");
	a_mul_result: assert property (@(posedge clk) disable iff (!reset_n)
		(done && op_r == MDU_OP_MUL) |=> {data_r[3], data_r[2], data_r[1], data_r[0]}
			== $past({data_r[1], data_r[0]}) * $past({data_r[5], data_r[4]}))
		else $error("product wrong");
	a_err_busy: assert property (@(posedge clk) disable iff (!reset_n)
		(data_acc && busy) |=> seq_err_r)
		else $error("busy access not flagged");
	a_err_clear: assert property (@(posedge clk) disable iff (!reset_n)
		(rd && addr == MDU_ADDR_STATUS && !bad_order && !(data_acc && busy)) |=> !seq_err_r)
		else $error("status read did not clear");
	a_ovf_zero: assert property (@(posedge clk) disable iff (!reset_n)
		(done && op_r != MDU_OP_MUL && data_r[4] == 8'h00 && data_r[5] == 8'h00) |=> ovf_r)
		else $error("divide by zero not flagged");
	a_bad_nostart: assert property (@(posedge clk) disable iff (!reset_n)
		(wr && addr == MDU_ADDR_BYTE5 && seq_r == MDU_SQ_W0 && !busy) |=> !busy)
		else $error("bad order started");

	// ****************************************
	// Order tracking checks
	// ****************************************
	a_short_track: assert property (@(posedge clk) disable iff (!reset_n)
		s_short_order |=> seq_r == MDU_SQ_W014)
		else $error("short order not tracked");
	a_mul_track: assert property (@(posedge clk) disable iff (!reset_n)
		s_mul_order |=> seq_r == MDU_SQ_W041)
		else $error("multiply order not tracked");
	a_zero_restart: assert property (@(posedge clk) disable iff (!reset_n)
		s_zero_write |=> seq_r == MDU_SQ_W0)
		else $error("register 0 did not restart tracking");
	a_bad_flag: assert property (@(posedge clk) disable iff (!reset_n)
		bad_order |=> seq_err_r)
		else $error("order error not flagged");

	// ****************************************
	// Calculation checks
	// ****************************************
	a_result_hold: assert property (@(posedge clk) disable iff (!reset_n)
		s_calc_quiet |=> $stable(data_r[0]) && $stable(data_r[1]) && $stable(data_r[2])
			&& $stable(data_r[3]) && $stable(data_r[4]) && $stable(data_r[5]))
		else $error("data changed during calculation");
	a_busy_read: assert property (@(posedge clk) disable iff (!reset_n)
		s_busy_read |=> rdata == 8'h00)
		else $error("busy read returned data");
	a_done_irq: assert property (@(posedge clk) disable iff (!reset_n)
		done |=> irq_st_r[MDU_IRQ_DONE_BIT])
		else $error("completion not flagged");

	// ****************************************
	// Result checks
	// ****************************************
	a_mul_ovf: assert property (@(posedge clk) disable iff (!reset_n)
		s_mul_done |=> ovf_r == ($past({data_r[1], data_r[0]}) * $past({data_r[5], data_r[4]}) > 32'h0000_FFFF))
		else $error("multiply overflow wrong");
	a_sdiv_quot: assert property (@(posedge clk) disable iff (!reset_n)
		s_sdiv_done |=> {data_r[1], data_r[0]} == $past({data_r[1], data_r[0]}) / $past({data_r[5], data_r[4]}))
		else $error("short quotient wrong");
	a_sdiv_rem: assert property (@(posedge clk) disable iff (!reset_n)
		s_sdiv_done |=> {data_r[5], data_r[4]} == $past({data_r[1], data_r[0]}) % $past({data_r[5], data_r[4]}))
		else $error("short remainder wrong");
	a_ldiv_quot: assert property (@(posedge clk) disable iff (!reset_n)
		s_ldiv_done |=> {data_r[3], data_r[2], data_r[1], data_r[0]}
			== $past({data_r[3], data_r[2], data_r[1], data_r[0]}) / {16'h0000, $past({data_r[5], data_r[4]})})
		else $error("long quotient wrong");
	a_ldiv_ovf: assert property (@(posedge clk) disable iff (!reset_n)
		s_ldiv_done |=> !ovf_r)
		else $error("long divide flagged overflow");

	// ****************************************
	// Status read checks
	// ****************************************
	a_status_pad: assert property (@(posedge clk) disable iff (!reset_n)
		s_status_read |=> rdata[5:0] == 6'h00)
		else $error("status low bits not zero");
	a_status_bits: assert property (@(posedge clk) disable iff (!reset_n)
		s_status_read |=> rdata[7:6] == $past({seq_err_r, ovf_r}))
		else $error("status flags read wrong");

endmodule // mdu_unit

// ---- verification/mdu_unit_test.sv ----
// Self-checking bench for the multiply / divide unit
// Assumes mdu_pkg and mdu_unit; the bench drives the register port directly
`timescale 1ns/1ps
module mdu_unit_test;
	import mdu_pkg::*;

	logic        clk;
	logic        reset_n;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic        busy;
	logic        irq;
	int          n_errors;
	int          checks;
	bit          ovf_last;
	logic [7:0]  d;
	int          nb;

	mdu_unit dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .busy(busy), .irq(irq));

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		results();
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic results();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	task automatic count_busy(output int c);
		c = 0;
		repeat (30) begin
			@(negedge clk);
			if (busy === 1'b1) c++;
		end
	endtask

	// Kind 0 long divide, 1 short divide, 2 multiply; poke writes during busy
	task automatic do_op(input int k, input logic [31:0] a, input logic [15:0] b, input bit poke);
		logic [3:0] ad [6];
		logic [7:0] dv [6];
		int         n;
		int         c;
		longint     q;
		longint     r;
		bit         ovf;
		logic [7:0] v;
		int         eq [$];
		n = (k == 0) ? 6 : 4;
		ad = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
		dv = '{a[7:0], a[15:8], a[23:16], a[31:24], b[7:0], b[15:8]};
		if (k == 1) begin
			ad = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h0, 4'h0};
			dv = '{a[7:0], a[15:8], b[7:0], b[15:8], 8'h00, 8'h00};
		end else if (k == 2) begin
			ad = '{4'h0, 4'h4, 4'h1, 4'h5, 4'h0, 4'h0};
			dv = '{a[7:0], b[7:0], a[15:8], b[15:8], 8'h00, 8'h00};
		end
		for (int i = 0; i < n; i++) begin
			if (i > 0) repeat ($urandom_range(2, 0)) @(posedge clk);
			wr_reg(ad[i], dv[i]);
		end
		if (poke) wr_reg(4'h0, 8'hA5);
		count_busy(c);
		chk(c, ((k == 0) ? 17 : (k == 1) ? 9 : 11) - 1 - (poke ? 2 : 0));
		ovf = 1'b0;
		if (k == 2) begin
			q = a[15:0] * b;
			ovf = (q > 64'hFFFF);
		end else if (b == 16'h0000) begin
			ovf = 1'b1;
		end else begin
			q = ((k == 0) ? a : {16'h0000, a[15:0]}) / b;
			r = ((k == 0) ? a : {16'h0000, a[15:0]}) % b;
		end
		if (k == 2 || b != 16'h0000) begin
			for (int i = 0; i < 4; i++)
				if (k != 1 || i < 2) eq.push_back((i << 8) | ((q >> (8 * i)) & 255));
			if (k != 2) begin
				eq.push_back(32'h400 | (r & 255));
				eq.push_back(32'h500 | ((r >> 8) & 255));
			end
		end
		rd_reg(MDU_ADDR_STATUS, v);
		chk(v, {poke, ovf, 6'h00});
		foreach (eq[i]) begin
			repeat ($urandom_range(2, 0)) @(posedge clk);
			rd_reg(4'(eq[i] >> 8), v);
			chk(v, eq[i] & 255);
		end
		ovf_last = ovf;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset_n = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		n_errors = 0;
		checks = 0;
		void'($urandom(32'h52fd2140));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rd_reg(MDU_ADDR_STATUS, d);
		chk(d, MDU_STATUS_RST);
		for (int t = 0; t < 9; t++) do_op(t % 3, $urandom, 16'($urandom), 1'b0);
		do_op(2, 32'h0000_00FF, 16'h0101, 1'b0);
		do_op(2, 32'h0000_0100, 16'h0100, 1'b0);
		do_op(0, 32'hFFFF_FFFF, 16'h0001, 1'b0);
		do_op(0, $urandom, 16'h0000, 1'b0);
		do_op(1, $urandom, 16'h0000, 1'b0);
		do_op(2, $urandom, 16'($urandom), 1'b1);
		$display("test operations done");
		wr_reg(4'h0, 8'h12);
		wr_reg(4'h2, 8'h34);
		wr_reg(4'h5, 8'h56);
		wr_reg(4'h0, 8'h12);
		wr_reg(4'h5, 8'h56);
		count_busy(nb);
		chk(nb, 0);
		rd_reg(MDU_ADDR_STATUS, d);
		chk(d, {1'b1, ovf_last, 6'h00});
		rd_reg(MDU_ADDR_STATUS, d);
		chk(d, {1'b0, ovf_last, 6'h00});
		$display("test order error done");
		@(negedge clk);
		chk(irq, 1'b0);
		wr_reg(MDU_ADDR_IRQ_MSK, 8'h03);
		rd_reg(MDU_ADDR_IRQ_MSK, d);
		chk(d, 8'h03);
		chk(irq, 1'b1);
		wr_reg(MDU_ADDR_IRQ_ST, 8'h03);
		@(negedge clk);
		chk(irq, 1'b0);
		rd_reg(MDU_ADDR_IRQ_ST, d);
		chk(d, 8'h00);
		wr_reg(4'h9, 8'hFF);
		rd_reg(4'h9, d);
		chk(d, 8'h00);
		$display("test interrupt and map done");
		results();
	end
endmodule // mdu_unit_test
